// ---- verilog/vlr_letterbox_readback.sv ----
// vbi data and letterbox status bank behind the serial control port
`timescale 1ns/1ps
`include "vlr_regs.svh"

module vlr_letterbox_readback #(
  parameter logic [6:0] DEV_ADDR = `VLR_DEV_ADDR,
  parameter int ACTIVE_LINES = `VLR_ACTIVE_LINES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic edtvThreeValid,
  input wire logic [7:0] edtvThreeData,
  input wire logic cgmsValid,
  input wire vlr_pkg::vlr_copy_mgmt_t cgmsData,
  input wire logic cgmsCrcOk,
  input wire logic crcEnable,
  input wire logic ccapValid,
  input wire vlr_pkg::vlr_caption_t ccapData,
  input wire logic fieldStart,
  input wire logic fieldEnd,
  input wire logic lineStrobe,
  input wire logic lineBlack,
  input wire logic subtitleDetected,
  output logic captionDetectedFlag,
  output logic copyMgmtDetectedFlag
);

  localparam logic [9:0] HALF_LINE = 10'(ACTIVE_LINES / 2);

  generate
    if (ACTIVE_LINES < 2 || ACTIVE_LINES > 1023) begin : g_bad_lines
      $error("vlr_letterbox_readback: ACTIVE_LINES out of range");
    end
  endgenerate

  // ----------------------------------------
  // vbi data capture
  // ----------------------------------------
  logic [`VLR_EDTV_KEEP_W-1:0] edtvThree_r, edtvThree_nxt;
  vlr_pkg::vlr_copy_mgmt_t copyMgmt_r, copyMgmt_nxt;
  vlr_pkg::vlr_caption_t caption_r, caption_nxt;
  logic capFlag_r, capFlag_nxt, capSeen_r, capSeen_nxt;
  logic copyFlag_r, copyFlag_nxt, copySeen_r, copySeen_nxt;
  logic copyAccept;

  assign copyAccept = cgmsValid && (!crcEnable || cgmsCrcOk);

  always_comb begin
    edtvThree_nxt = edtvThree_r;
    copyMgmt_nxt = copyMgmt_r;
    caption_nxt = caption_r;
    if (edtvThreeValid) begin
      edtvThree_nxt = edtvThreeData[`VLR_EDTV_KEEP_W-1:0];
    end
    if (cgmsValid) begin
      copyMgmt_nxt = cgmsData;
    end
    if (ccapValid) begin
      caption_nxt = ccapData;
    end
    capSeen_nxt = ccapValid || (capSeen_r && !fieldEnd);
    capFlag_nxt = capFlag_r;
    if (ccapValid) begin
      capFlag_nxt = 1'b1;
    end else if (fieldEnd && !capSeen_r) begin
      capFlag_nxt = 1'b0;
    end
    copySeen_nxt = copyAccept || (copySeen_r && !fieldEnd);
    copyFlag_nxt = copyFlag_r;
    if (copyAccept) begin
      copyFlag_nxt = 1'b1;
    end else if (fieldEnd && !copySeen_r) begin
      copyFlag_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      edtvThree_r <= '0;
      copyMgmt_r <= '0;
      caption_r <= '0;
      capFlag_r <= 1'b0;
      capSeen_r <= 1'b0;
      copyFlag_r <= 1'b0;
      copySeen_r <= 1'b0;
    end else begin
      edtvThree_r <= edtvThree_nxt;
      copyMgmt_r <= copyMgmt_nxt;
      caption_r <= caption_nxt;
      capFlag_r <= capFlag_nxt;
      capSeen_r <= capSeen_nxt;
      copyFlag_r <= copyFlag_nxt;
      copySeen_r <= copySeen_nxt;
    end
  end

  assign captionDetectedFlag = capFlag_r;
  assign copyMgmtDetectedFlag = copyFlag_r;

  // ----------------------------------------
  // letterbox measurement
  // ----------------------------------------
  logic [9:0] lineIdx_r, lineIdx_nxt;
  logic lowerHalf;
  logic [7:0] topCnt, subCnt, botCnt;
  logic [7:0] topCount_r, topCount_nxt;
  logic [7:0] subCount_r, subCount_nxt;
  logic [7:0] botCount_r, botCount_nxt;

  assign lowerHalf = lineIdx_r >= HALF_LINE;

  // start of field clears, end of field latches
  vlr_line_counter #(.WIDTH(8)) u_top (
    .mclk(mclk),
    .rst(rst),
    .clr(fieldStart),
    .step(lineStrobe),
    .black(lineBlack),
    .mode(vlr_pkg::VLR_CNT_LEADING),
    .count(topCnt)
  );

  vlr_line_counter #(.WIDTH(8)) u_subtitle (
    .mclk(mclk),
    .rst(rst),
    .clr(fieldStart),
    .step(lineStrobe && lowerHalf),
    .black(lineBlack),
    .mode(vlr_pkg::VLR_CNT_TOTAL),
    .count(subCnt)
  );

  vlr_line_counter #(.WIDTH(8)) u_bottom (
    .mclk(mclk),
    .rst(rst),
    .clr(fieldStart),
    .step(lineStrobe),
    .black(lineBlack),
    .mode(vlr_pkg::VLR_CNT_TRAILING),
    .count(botCnt)
  );

  always_comb begin
    lineIdx_nxt = lineIdx_r;
    if (fieldStart) begin
      lineIdx_nxt = 10'h000;
    end else if (lineStrobe && lineIdx_r != 10'h3FF) begin
      lineIdx_nxt = lineIdx_r + 10'h001;
    end
    topCount_nxt = topCount_r;
    subCount_nxt = subCount_r;
    botCount_nxt = botCount_r;
    // picture content only, no vbi input involved
    if (fieldEnd) begin
      topCount_nxt = topCnt;
      subCount_nxt = subtitleDetected ? subCnt : 8'h00;
      botCount_nxt = botCnt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lineIdx_r <= 10'h000;
      topCount_r <= `VLR_DATA_RESET;
      subCount_r <= `VLR_DATA_RESET;
      botCount_r <= `VLR_DATA_RESET;
    end else begin
      lineIdx_r <= lineIdx_nxt;
      topCount_r <= topCount_nxt;
      subCount_r <= subCount_nxt;
      botCount_r <= botCount_nxt;
    end
  end

  // ----------------------------------------
  // register read side
  // ----------------------------------------
  logic [7:0] rdAddr;
  logic [7:0] rdData;

  // pure mux, reads have no side effect
  always_comb begin
    case (rdAddr)
      `VLR_OFS_EDTV_THREE: rdData = {{(8-`VLR_EDTV_KEEP_W){1'b0}}, edtvThree_r};
      `VLR_OFS_COPY_ONE: rdData = copyMgmt_r.byteOne;
      `VLR_OFS_COPY_TWO: rdData = copyMgmt_r.byteTwo;
      `VLR_OFS_COPY_THREE: rdData = copyMgmt_r.byteThree;
      `VLR_OFS_CAPTION_ONE: rdData = {caption_r.parityOne, caption_r.charOne};
      `VLR_OFS_CAPTION_TWO: rdData = {caption_r.parityTwo, caption_r.charTwo};
      `VLR_OFS_LB_TOP: rdData = topCount_r;
      `VLR_OFS_LB_SUBTITLE: rdData = subCount_r;
      `VLR_OFS_LB_BOTTOM: rdData = botCount_r;
      default: rdData = `VLR_UNMAPPED_DATA;
    endcase
  end

  vlr_serial_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
    .mclk(mclk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .rdData(rdData),
    .rdAddr(rdAddr),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_edtv_high_zero;
    @(posedge mclk) disable iff (rst) rdAddr == `VLR_OFS_EDTV_THREE |-> rdData[7:5] == 3'h0;
  endproperty
  a_edtv_high_zero: assert property (p_edtv_high_zero) else $error("edtv reserved bits not zero");

  property p_caption_one;
    @(posedge mclk) disable iff (rst)
      ccapValid |=> {caption_r.parityOne, caption_r.charOne} == $past(ccapData[15:8]);
  endproperty
  a_caption_one: assert property (p_caption_one) else $error("caption one layout wrong");

  property p_caption_two;
    @(posedge mclk) disable iff (rst) ccapValid |=> caption_r.parityTwo == $past(ccapData.parityTwo);
  endproperty
  a_caption_two: assert property (p_caption_two) else $error("caption two parity wrong");

  property p_top_latch;
    @(posedge mclk) disable iff (rst) fieldEnd |=> topCount_r == $past(topCnt);
  endproperty
  a_top_latch: assert property (p_top_latch) else $error("top count not latched");

  property p_sub_zero;
    @(posedge mclk) disable iff (rst) fieldEnd && !subtitleDetected |=> subCount_r == 8'h00;
  endproperty
  a_sub_zero: assert property (p_sub_zero) else $error("subtitle count without subtitles");

  property p_bot_latch;
    @(posedge mclk) disable iff (rst) fieldEnd |=> botCount_r == $past(botCnt);
  endproperty
  a_bot_latch: assert property (p_bot_latch) else $error("bottom count not latched");

  property p_cap_flag;
    @(posedge mclk) disable iff (rst) ccapValid |=> captionDetectedFlag ##1 (captionDetectedFlag || capSeen_r == 1'b0);
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("caption flag not set");

  property p_crc_gate;
    @(posedge mclk) disable iff (rst)
      !copyFlag_r && cgmsValid && crcEnable && !cgmsCrcOk |=> !copyMgmtDetectedFlag;
  endproperty
  a_crc_gate: assert property (p_crc_gate) else $error("flag set on bad checksum");

  property p_hold_counts;
    @(posedge mclk) disable iff (rst)
      !fieldEnd |=> $stable(botCount_r) && $stable(topCount_r) && $stable(subCount_r);
  endproperty
  a_hold_counts: assert property (p_hold_counts) else $error("count changed outside field end");

endmodule

// ---- inc/vlr_regs.svh ----
// register offsets, field positions and defaults of the readback bank
`ifndef VLR_REGS_SVH
`define VLR_REGS_SVH

// ----------------------------------------
// register offsets (serial subaddress)
// ----------------------------------------
`define VLR_OFS_EDTV_THREE 8'h95
`define VLR_OFS_COPY_ONE 8'h96
`define VLR_OFS_COPY_TWO 8'h97
`define VLR_OFS_COPY_THREE 8'h98
`define VLR_OFS_CAPTION_ONE 8'h99
`define VLR_OFS_CAPTION_TWO 8'h9A
`define VLR_OFS_LB_TOP 8'h9B
`define VLR_OFS_LB_SUBTITLE 8'h9C
`define VLR_OFS_LB_BOTTOM 8'h9D

// ----------------------------------------
// field layout and defaults
// ----------------------------------------
`define VLR_EDTV_KEEP_W 5
`define VLR_UNMAPPED_DATA 8'h00
`define VLR_DATA_RESET 8'h00
// arbitrary slave address
`define VLR_DEV_ADDR 7'h20
`define VLR_ACTIVE_LINES 240
`define VLR_SUBADDR_RESET 8'h00

`endif

// ---- inc/vlr_pkg.sv ----
// types shared by the readback bank
package vlr_pkg;

  typedef struct packed {
    logic parityOne;
    logic [6:0] charOne;
    logic parityTwo;
    logic [6:0] charTwo;
  } vlr_caption_t;

  typedef struct packed {
    logic [7:0] byteOne;
    logic [7:0] byteTwo;
    logic [7:0] byteThree;
  } vlr_copy_mgmt_t;

  typedef enum logic [2:0] {
    VLR_CNT_LEADING = 3'b001,
    VLR_CNT_TRAILING = 3'b010,
    VLR_CNT_TOTAL = 3'b100
  } vlr_count_mode_t;

  typedef enum logic [6:0] {
    VLR_SL_IDLE = 7'b0000001,
    VLR_SL_RX_ADDR = 7'b0000010,
    VLR_SL_RX_SUB = 7'b0000100,
    VLR_SL_RX_DATA = 7'b0001000,
    VLR_SL_ACK = 7'b0010000,
    VLR_SL_TX_DATA = 7'b0100000,
    VLR_SL_TX_ACK = 7'b1000000
  } vlr_slave_state_t;

endpackage

// ---- verilog/vlr_line_counter.sv ----
// saturating black line counter with leading, trailing and total modes
`timescale 1ns/1ps
`include "vlr_regs.svh"

module vlr_line_counter #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  input wire logic step,
  input wire logic black,
  input wire vlr_pkg::vlr_count_mode_t mode,
  output logic [WIDTH-1:0] count
);

  generate
    if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
      $error("vlr_line_counter: WIDTH out of range");
    end
  endgenerate

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic broken_r;
  logic broken_nxt;
  logic sat;

  assign sat = &count_r;
  assign count = count_r;

  always_comb begin
    count_nxt = count_r;
    broken_nxt = broken_r;
    if (clr) begin
      count_nxt = '0;
      broken_nxt = 1'b0;
    end else if (step) begin
      unique case (mode)
        vlr_pkg::VLR_CNT_LEADING: begin
          // run from field start stops at the first picture line
          if (broken_r || !black) begin
            broken_nxt = 1'b1;
          end else if (!sat) begin
            count_nxt = count_r + 1'b1;
          end
        end
        vlr_pkg::VLR_CNT_TRAILING: begin
          if (!black) begin
            count_nxt = '0;
          end else if (!sat) begin
            count_nxt = count_r + 1'b1;
          end
        end
        vlr_pkg::VLR_CNT_TOTAL: begin
          if (black && !sat) begin
            count_nxt = count_r + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_r <= '0;
      broken_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      broken_r <= broken_nxt;
    end
  end

  property p_clear_count;
    @(posedge mclk) disable iff (rst) clr |=> count_r == '0;
  endproperty
  a_clear_count: assert property (p_clear_count) else $error("count not cleared at field start");

endmodule

// ---- verilog/vlr_serial_slave.sv ----
// two-wire serial read port with auto-incrementing subaddress
`timescale 1ns/1ps
`include "vlr_regs.svh"

module vlr_serial_slave #(
  parameter logic [6:0] DEV_ADDR = `VLR_DEV_ADDR
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic [7:0] rdData,
  output logic [7:0] rdAddr,
  output logic sdaOut,
  output logic sdaOe
);

  vlr_pkg::vlr_slave_state_t state_r, state_nxt, after_r, after_nxt;
  logic sclP_r, sdaP_r;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt, sub_r, sub_nxt;
  logic oe_r, oe_nxt, mack_r, mack_nxt;
  logic start, stop, rise, fall;

  assign start = sclIn && sclP_r && sdaP_r && !sdaIn;
  assign stop = sclIn && sclP_r && !sdaP_r && sdaIn;
  assign rise = sclIn && !sclP_r;
  assign fall = !sclIn && sclP_r;
  assign rdAddr = sub_r;
  assign sdaOe = oe_r;
  // open drain: only ever pulls low
  assign sdaOut = 1'b0;

  always_comb begin
    state_nxt = state_r;
    after_nxt = after_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    sub_nxt = sub_r;
    oe_nxt = oe_r;
    mack_nxt = mack_r;
    if (stop) begin
      state_nxt = vlr_pkg::VLR_SL_IDLE;
      oe_nxt = 1'b0;
    end else if (start) begin
      state_nxt = vlr_pkg::VLR_SL_RX_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        vlr_pkg::VLR_SL_IDLE: begin
        end
        vlr_pkg::VLR_SL_RX_ADDR, vlr_pkg::VLR_SL_RX_SUB, vlr_pkg::VLR_SL_RX_DATA: begin
          if (rise) begin
            shift_nxt = {shift_r[6:0], sdaIn};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == 4'h8) begin
            cnt_nxt = 4'h0;
            oe_nxt = 1'b1;
            state_nxt = vlr_pkg::VLR_SL_ACK;
            if (state_r == vlr_pkg::VLR_SL_RX_ADDR) begin
              if (shift_r[7:1] != DEV_ADDR) begin
                oe_nxt = 1'b0;
                state_nxt = vlr_pkg::VLR_SL_IDLE;
              end else begin
                after_nxt = shift_r[0] ? vlr_pkg::VLR_SL_TX_DATA : vlr_pkg::VLR_SL_RX_SUB;
              end
            end else if (state_r == vlr_pkg::VLR_SL_RX_SUB) begin
              sub_nxt = shift_r;
              after_nxt = vlr_pkg::VLR_SL_RX_DATA;
            end else begin
              // bank is read-only: written bytes are acked and dropped
              sub_nxt = sub_r + 8'h01;
              after_nxt = vlr_pkg::VLR_SL_RX_DATA;
            end
          end
        end
        vlr_pkg::VLR_SL_ACK: begin
          if (fall) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            state_nxt = after_r;
            if (after_r == vlr_pkg::VLR_SL_TX_DATA) begin
              shift_nxt = rdData;
              oe_nxt = ~rdData[7];
              sub_nxt = sub_r + 8'h01;
            end
          end
        end
        vlr_pkg::VLR_SL_TX_DATA: begin
          if (fall) begin
            if (cnt_r == 4'h7) begin
              oe_nxt = 1'b0;
              state_nxt = vlr_pkg::VLR_SL_TX_ACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt = ~shift_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        vlr_pkg::VLR_SL_TX_ACK: begin
          if (rise) begin
            mack_nxt = !sdaIn;
          end else if (fall) begin
            if (mack_r) begin
              shift_nxt = rdData;
              oe_nxt = ~rdData[7];
              sub_nxt = sub_r + 8'h01;
              cnt_nxt = 4'h0;
              state_nxt = vlr_pkg::VLR_SL_TX_DATA;
            end else begin
              state_nxt = vlr_pkg::VLR_SL_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= vlr_pkg::VLR_SL_IDLE;
      after_r <= vlr_pkg::VLR_SL_IDLE;
      sclP_r <= 1'b1;
      sdaP_r <= 1'b1;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      sub_r <= `VLR_SUBADDR_RESET;
      oe_r <= 1'b0;
      mack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      after_r <= after_nxt;
      sclP_r <= sclIn;
      sdaP_r <= sdaIn;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      sub_r <= sub_nxt;
      oe_r <= oe_nxt;
      mack_r <= mack_nxt;
    end
  end

endmodule

// ---- dv/vlr_host_model.sv ----
// serial host model that reads and writes the readback bank
`timescale 1ns/1ps

module vlr_host_model (
  input wire logic mclk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaPullLow
);
  // ----------------------------------------
  // bus state
  // ----------------------------------------
  // four mclk per phase keeps both clock phases above the two-cycle minimum
  localparam int HALF = 4;
  logic [7:0] rxQ [$];
  logic lastAck;

  initial begin
    scl = 1'b1;
    sdaPullLow = 1'b0;
    lastAck = 1'b0;
  end

  // ----------------------------------------
  // bit and byte level
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic start();
    sdaPullLow = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sdaPullLow = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask

  task automatic stop();
    sdaPullLow = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sdaPullLow = 1'b0;
    tick(HALF);
  endtask

  // data only moves while the clock is low, so no false start or stop
  task automatic clockBit(input logic drive, output logic seen);
    sdaPullLow = ~drive;
    tick(HALF);
    scl = 1'b1;
    tick(HALF / 2);
    seen = sdaLine;
    tick(HALF / 2);
    scl = 1'b0;
  endtask

  task automatic sendByte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clockBit(b[i], s);
    end
    clockBit(1'b1, s);
    lastAck = lastAck & ~s;
  endtask

  // ----------------------------------------
  // transactions
  // ----------------------------------------
  task automatic readBurst(input logic [6:0] dev, input logic [7:0] sub, input int n);
    logic [7:0] b;
    logic s;
    rxQ.delete();
    lastAck = 1'b1;
    start();
    sendByte({dev, 1'b0});
    sendByte(sub);
    start();
    sendByte({dev, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        clockBit(1'b1, b[i]);
      end
      rxQ.push_back(b);
      // nack on the last byte ends the read
      clockBit(k == n - 1, s);
    end
    stop();
  endtask

  task automatic writeByte(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] val);
    lastAck = 1'b1;
    start();
    sendByte({dev, 1'b0});
    sendByte(sub);
    sendByte(val);
    stop();
  endtask
endmodule

// ---- dv/test_vlr_letterbox_readback.sv ----
// self-checking bench for the vbi and letterbox readback bank
`timescale 1ns/1ps
`include "vlr_regs.svh"
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module test_vlr_letterbox_readback;
  // ----------------------------------------
  // stimulus and bench model
  // ----------------------------------------
  // short active height so fields reach both halves quickly
  localparam int LINES = 16;
  localparam logic [6:0] DEV = `VLR_DEV_ADDR;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic hostLow;
  logic sdaLine;
  logic sdaOut;
  logic sdaOe;
  logic edtvThreeValid = 1'b0;
  logic [7:0] edtvThreeData = 8'h00;
  logic cgmsValid = 1'b0;
  vlr_pkg::vlr_copy_mgmt_t cgmsData = '0;
  logic cgmsCrcOk = 1'b0;
  logic crcEnable = 1'b1;
  logic ccapValid = 1'b0;
  vlr_pkg::vlr_caption_t ccapData = '0;
  logic fieldStart = 1'b0;
  logic fieldEnd = 1'b0;
  logic lineStrobe = 1'b0;
  logic lineBlack = 1'b0;
  logic subtitleDetected = 1'b0;
  logic capFlag;
  logic cpyFlag;
  logic [7:0] expReg [0:9];
  logic expCap;
  logic expCpy;
  logic capEvt;
  logic cpyEvt;
  logic [31:0] seed = 32'h0BBD;
  logic [31:0] rv;
  int mismatches = 0;
  int checkCount = 0;

  always #12.5 mclk = ~mclk;
  // open-drain data line with pull-up
  assign sdaLine = ~((sdaOe & ~sdaOut) | hostLow);

  vlr_host_model i_vlr_host_model (.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaPullLow(hostLow));

  vlr_letterbox_readback #(.ACTIVE_LINES(LINES)) i_vlr_letterbox_readback (
    .mclk(mclk), .rst(rst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .edtvThreeValid(edtvThreeValid), .edtvThreeData(edtvThreeData), .cgmsValid(cgmsValid), .cgmsData(cgmsData),
    .cgmsCrcOk(cgmsCrcOk), .crcEnable(crcEnable), .ccapValid(ccapValid), .ccapData(ccapData),
    .fieldStart(fieldStart), .fieldEnd(fieldEnd), .lineStrobe(lineStrobe), .lineBlack(lineBlack),
    .subtitleDetected(subtitleDetected), .captionDetectedFlag(capFlag), .copyMgmtDetectedFlag(cpyFlag));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic doReset();
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    foreach (expReg[i]) expReg[i] = 8'h00;
    expCap = 1'b0;
    expCpy = 1'b0;
    capEvt = 1'b0;
    cpyEvt = 1'b0;
  endtask

  // burst over the whole bank plus one unmapped place
  task automatic checkBank();
    i_vlr_host_model.readBurst(DEV, `VLR_OFS_EDTV_THREE, 10);
    `CHK(i_vlr_host_model.lastAck, 1'b1)
    for (int i = 0; i < 10; i++) begin
      `CHK(i_vlr_host_model.rxQ[i], expReg[i])
    end
    `CHK(capFlag, expCap)
    `CHK(cpyFlag, expCpy)
  endtask

  task automatic sendVbi(input logic crcGood);
    logic [31:0] r;
    logic [31:0] q;
    r = xs();
    q = xs();
    edtvThreeData = r[7:0];
    ccapData = r[31:16];
    cgmsData = q[23:0];
    cgmsCrcOk = crcGood;
    edtvThreeValid = 1'b1;
    cgmsValid = 1'b1;
    ccapValid = 1'b1;
    @(negedge mclk);
    edtvThreeValid = 1'b0;
    cgmsValid = 1'b0;
    ccapValid = 1'b0;
    expReg[0] = {3'b000, r[4:0]};
    expReg[1] = q[23:16];
    expReg[2] = q[15:8];
    expReg[3] = q[7:0];
    expReg[4] = r[31:24];
    expReg[5] = r[23:16];
    expCap = 1'b1;
    capEvt = 1'b1;
    if (!crcEnable || crcGood) begin
      expCpy = 1'b1;
      cpyEvt = 1'b1;
    end
    @(negedge mclk);
    `CHK(capFlag, expCap)
    `CHK(cpyFlag, expCpy)
  endtask

  // strobes that coincide with field start or end carry a grey line
  task automatic runField(input int n, input logic subt, input logic allBlack);
    logic blk [$];
    int top;
    int bot;
    int mid;
    int lead;
    int trail;
    lead = xs() % 5;
    trail = xs() % 5;
    for (int i = 0; i < n; i++) blk.push_back(allBlack || i < lead || i >= n - trail || xs() % 3 == 0);
    top = 0;
    while (top < n && blk[top]) top++;
    bot = 0;
    while (bot < n && blk[n - 1 - bot]) bot++;
    mid = 0;
    for (int i = LINES / 2; i < n; i++) mid += (subt && blk[i]) ? 1 : 0;
    fieldStart = 1'b1;
    lineStrobe = 1'b1;
    lineBlack = 1'b0;
    @(negedge mclk);
    fieldStart = 1'b0;
    for (int i = 0; i < n; i++) begin
      lineStrobe = 1'b1;
      lineBlack = blk[i];
      @(negedge mclk);
      lineStrobe = 1'b0;
      @(negedge mclk);
    end
    fieldEnd = 1'b1;
    lineStrobe = 1'b1;
    lineBlack = 1'b0;
    subtitleDetected = subt;
    @(negedge mclk);
    fieldEnd = 1'b0;
    lineStrobe = 1'b0;
    expReg[6] = (top > 255) ? 8'hFF : top[7:0];
    expReg[7] = (mid > 255) ? 8'hFF : mid[7:0];
    expReg[8] = (bot > 255) ? 8'hFF : bot[7:0];
    expCap = expCap & capEvt;
    expCpy = expCpy & cpyEvt;
    capEvt = 1'b0;
    cpyEvt = 1'b0;
    @(negedge mclk);
    checkBank();
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    doReset();
    checkBank();
    i_vlr_host_model.readBurst(DEV ^ 7'h01, `VLR_OFS_LB_TOP, 1);
    `CHK(i_vlr_host_model.lastAck, 1'b0)
    sendVbi(1'b0);
    sendVbi(1'b1);
    checkBank();
    runField(300, 1'b1, 1'b1);
    for (int f = 0; f < 8; f++) begin
      rv = xs();
      crcEnable = rv[7];
      if (f % 3 == 0) sendVbi(rv[6]);
      runField(4 + int'(rv[3:0] % 13), rv[4], 1'b0);
    end
    i_vlr_host_model.writeByte(DEV, `VLR_OFS_LB_TOP, 8'hA5);
    `CHK(i_vlr_host_model.lastAck, 1'b1)
    checkBank();
    doReset();
    checkBank();
    report_and_stop();
  end

  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
endmodule
